// *** rtl/rmst_core.sv ***
// module: mode sequencer with two chained interval timers, AHB-Lite regs
//
// Contract
// [RULE1] idle holds standby (0) or sleep (1)
// [RULE2] start transition: lowpower, rx, tx, tx-on-threshold
// [RULE3] lowpower choice: off at initial mode, or idle
// [RULE4] remember sleep/standby mode at launch
// [RULE5] idle exit on first timer: tx or rx
// [RULE6] tx exit on sent: lowpower or rx
// [RULE7] rx exit codes on payload or crc good
// [RULE8] rx exits off on level/sync/preamble events
// [RULE9] second timer in rx forces lowpower choice
// [RULE10] crc failure with payload goes to timeout
// [RULE11] timeout exit: relaunch rx, tx, lowpower, off
// [RULE12] any of three receiver timeouts counts
// [RULE13] packet-done exit: off, tx, lowpower, rx
// [RULE14] first timer fires interval after start or second
// [RULE15] second timer fires interval after first
// [RULE16] timers run whatever the sequencer state
// [RULE17] tick select: off, 64us, 4.1ms, 262ms
// [RULE18] multiplier scales tick into the interval
// [RULE19] stop forces off at once
// [RULE20] host never sets launch and stop together
// [RULE21] idle reacts to first timer only
// [RULE22] sequencer works only in fsk/ook mode
// [RULE23] multiplier eight bits, zero acts as one
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module rmst_core
   import rmst_pkg::*;
#(
   parameter int TICK2_CYC = TICK2_DEF,
   parameter int TICK3_CYC = TICK3_DEF
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        chip_in_lowpower,
   input  wire logic        chip_in_sleep,
   input  wire logic        tx_done_irq,
   input  wire logic        rx_payload_irq,
   input  wire logic        crc_good_irq,
   input  wire logic        rx_level_irq,
   input  wire logic        sync_match_irq,
   input  wire logic        preamble_seen_irq,
   input  wire logic        rx_level_timeout,
   input  wire logic        rx_preamble_timeout,
   input  wire logic        rx_sync_timeout,
   input  wire logic        fifo_level_irq,
   input  wire logic        fifo_drained_irq,
   output logic             seq_active,
   output logic      [2:0]  mode_req,
   output logic             rx_relaunch,
   output logic             first_timer_irq,
   output logic             second_timer_irq
);

   rmst_state_e st;
   rmst_state_e next_st;
   logic [7:0]  ctrl;
   logic [10:0] trans;
   logic [23:0] timer;
   logic        launch_p;
   logic        stop_p;
   logic        init_sleep;
   logic        wr_pend;
   logic [11:0] wr_addr;
   logic        t_run;
   logic        t_phase;
   logic [22:0] tick_cnt;
   logic [7:0]  mult_cnt;
   logic [1:0]  cur_sel;
   logic [7:0]  cur_mult;
   logic        tick_end;
   logic        fire;
   logic        t1_fire;
   logic        t2_fire;
   logic        launch_ok;
   logic        halt;
   logic        rx_tmo;
   logic        crc_bad;
   logic        addr_ok;
   logic [31:0] rd_val;

   // tick length in cycles for a two-bit select
   function automatic logic [22:0] res_count(input logic [1:0] sel);
      logic [22:0] r;
      r = 23'h000001;
      if (sel == 2'h1) begin
         r = 23'(TICK1_CYC); // [RULE17]
      end else if (sel == 2'h2) begin
         r = 23'(TICK2_CYC); // [RULE17]
      end else if (sel == 2'h3) begin
         r = 23'(TICK3_CYC); // [RULE17]
      end
      return r;
   endfunction

   function automatic logic [7:0] eff_mult(input logic [7:0] m);
      return (m == 8'h00) ? 8'h01 : m; // [RULE23]
   endfunction

   // ---------------- bus slave ----------------
   assign addr_ok = hsel && htrans[1] && hready && ce;

   // zero wait states: answer always ready and OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 12'h000;
      end else if (ce) begin
         wr_pend <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_addr <= haddr[11:0];
         end
      end
   end

   always_comb begin
      rd_val = 32'h00000000;
      if (haddr[11:0] == OFS_CTRL) begin
         rd_val[7:0] = ctrl;
      end else if (haddr[11:0] == OFS_TRANS) begin
         rd_val[10:0] = trans;
      end else if (haddr[11:0] == OFS_TIMER) begin
         rd_val[23:0] = timer;
      end else if (haddr[11:0] == OFS_STAT) begin
         rd_val[B_ST_LO +: 9]   = st;
         rd_val[B_MODE_LO +: 3] = mode_req;
         rd_val[B_INIT]         = init_sleep;
         rd_val[B_ACTIVE]       = seq_active;
      end
   end

   // read data captured in the address phase, stands in the data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (ce && addr_ok && !hwrite) begin
         hrdata <= rd_val;
      end
   end

   // launch and stop are self-clearing, they read back as zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl     <= CTRL_RST;
         trans    <= TRANS_RST;
         timer    <= TIMER_RST;
         launch_p <= 1'b0;
         stop_p   <= 1'b0;
      end else if (ce) begin
         launch_p <= 1'b0;
         stop_p   <= 1'b0;
         if (wr_pend && wr_addr == OFS_CTRL) begin
            ctrl     <= {hwdata[7:2], 2'h0};
            launch_p <= hwdata[B_LAUNCH];
            stop_p   <= hwdata[B_STOP];
         end else if (wr_pend && wr_addr == OFS_TRANS) begin
            trans <= hwdata[10:0];
         end else if (wr_pend && wr_addr == OFS_TIMER) begin
            timer <= hwdata[23:0];
         end
      end
   end

   // ---------------- timers ----------------
   assign launch_ok = launch_p && chip_in_lowpower && trans[B_FSK_ON]
                      && st == S_OFF;
   assign halt      = stop_p || !trans[B_FSK_ON]; // [RULE19] [RULE22]
   assign cur_sel   = t_phase ? timer[B_T2_SEL_LO +: 2]
                              : timer[B_T1_SEL_LO +: 2];
   assign cur_mult  = eff_mult(t_phase ? timer[B_T2_MUL_LO +: 8]
                                       : timer[B_T1_MUL_LO +: 8]);
   assign tick_end  = tick_cnt == res_count(cur_sel) - 23'h000001;
   // a disabled timer parks the chain, so cycling needs both enabled
   assign fire      = t_run && cur_sel != 2'h0 && tick_end
                      && mult_cnt == cur_mult - 8'h01; // [RULE16] [RULE18]
   assign t1_fire   = fire && !t_phase;
   assign t2_fire   = fire && t_phase;

   // the chain keeps running through every sequencer state
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         t_run    <= 1'b0;
         t_phase  <= 1'b0;
         tick_cnt <= 23'h000000;
         mult_cnt <= 8'h00;
      end else if (ce) begin
         if (halt) begin
            t_run    <= 1'b0;
            t_phase  <= 1'b0;
            tick_cnt <= 23'h000000;
            mult_cnt <= 8'h00;
         end else if (launch_ok) begin
            t_run    <= 1'b1; // [RULE14]
            t_phase  <= 1'b0;
            tick_cnt <= 23'h000000;
            mult_cnt <= 8'h00;
         end else if (t_run && cur_sel != 2'h0) begin // [RULE16]
            if (!tick_end) begin
               tick_cnt <= tick_cnt + 23'h000001;
            end else begin
               tick_cnt <= 23'h000000;
               if (fire) begin
                  mult_cnt <= 8'h00;
                  t_phase  <= !t_phase; // [RULE14] [RULE15]
               end else begin
                  mult_cnt <= mult_cnt + 8'h01;
               end
            end
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         first_timer_irq  <= 1'b0;
         second_timer_irq <= 1'b0;
      end else if (ce) begin
         first_timer_irq  <= t1_fire;
         second_timer_irq <= t2_fire;
      end
   end

   // ---------------- sequencer ----------------
   assign rx_tmo  = rx_level_timeout || rx_preamble_timeout
                    || rx_sync_timeout; // [RULE12]
   assign crc_bad = trans[B_CRC_ON] && !trans[B_CRC_FLUSH]
                    && !crc_good_irq;

   always_comb begin
      next_st = st;
      case (st)
         S_OFF: begin
            if (launch_ok) begin
               case (ctrl[B_START_LO +: 2]) // [RULE2]
                  2'h0:    next_st = S_LPSEL;
                  2'h1:    next_st = S_RX;
                  2'h2:    next_st = S_TX;
                  default: next_st = S_TXWAIT;
               endcase
            end
         end
         S_TXWAIT: begin
            if (fifo_level_irq) begin
               next_st = S_TX; // [RULE2]
            end
         end
         S_LPSEL: begin
            next_st = ctrl[B_LP_CHO] ? S_IDLE : S_OFF; // [RULE3]
         end
         S_IDLE: begin
            if (t1_fire) begin // [RULE21]
               next_st = ctrl[B_IDLE_EX] ? S_RX : S_TX; // [RULE5]
            end
         end
         S_TX: begin
            if (tx_done_irq) begin
               next_st = ctrl[B_TX_EX] ? S_RX : S_LPSEL; // [RULE6]
            end
         end
         S_RX: begin
            if (t2_fire) begin
               next_st = S_LPSEL; // [RULE9]
            end else begin
               case (trans[B_RX_EX_LO +: 3]) // [RULE7] [RULE8]
                  3'h1: if (rx_payload_irq) next_st = S_PKT;
                  3'h2: if (rx_payload_irq) next_st = S_LPSEL;
                  3'h3: begin
                     if (crc_good_irq) begin
                        next_st = S_PKT;
                     end else if (rx_payload_irq && crc_bad) begin
                        next_st = S_TMO; // [RULE10]
                     end
                  end
                  3'h4: if (rx_level_irq) next_st = S_OFF;
                  3'h5: if (sync_match_irq) next_st = S_OFF;
                  3'h6: if (preamble_seen_irq) next_st = S_OFF;
                  default: next_st = S_RX;
               endcase
               if (next_st == S_RX && rx_tmo) begin
                  next_st = S_TMO; // [RULE12]
               end
            end
         end
         S_TMO: begin
            case (trans[B_TMO_EX_LO +: 2]) // [RULE11]
               2'h0:    next_st = S_RX;
               2'h1:    next_st = S_TX;
               2'h2:    next_st = S_LPSEL;
               default: next_st = S_OFF;
            endcase
         end
         S_PKT: begin
            case (trans[B_PKT_EX_LO +: 3]) // [RULE13]
               3'h0: next_st = S_OFF;
               3'h1: if (fifo_drained_irq) next_st = S_TX;
               3'h2: next_st = S_LPSEL;
               3'h3: next_st = S_FSHOP;
               3'h4: next_st = S_RX;
               default: next_st = S_PKT;
            endcase
         end
         S_FSHOP: begin
            next_st = S_RX; // [RULE13]
         end
         default: next_st = S_OFF;
      endcase
      if (halt) begin
         next_st = S_OFF; // [RULE19] [RULE22]
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= S_OFF;
      end else if (ce) begin
         st <= next_st;
      end
   end

   // initial mode caught on the accepted launch
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         init_sleep <= 1'b0;
      end else if (ce && launch_ok) begin
         init_sleep <= chip_in_sleep; // [RULE4]
      end
   end

   // lowpower-choice and timeout states keep the mode already requested
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_req    <= M_STBY;
         seq_active  <= 1'b0;
         rx_relaunch <= 1'b0;
      end else if (ce) begin
         seq_active  <= next_st != S_OFF;
         rx_relaunch <= st == S_TMO && next_st == S_RX; // [RULE11]
         case (next_st)
            S_OFF, S_TXWAIT: begin
               if (launch_ok) begin
                  mode_req <= chip_in_sleep ? M_SLEEP : M_STBY;
               end else begin
                  mode_req <= init_sleep ? M_SLEEP : M_STBY; // [RULE3]
               end
            end
            S_IDLE:       mode_req <= ctrl[B_IDLE_LP] ? M_SLEEP
                                                      : M_STBY; // [RULE1]
            S_TX:         mode_req <= M_TX;
            S_RX, S_PKT:  mode_req <= M_RX;
            S_FSHOP:      mode_req <= M_FS;
            default:      mode_req <= mode_req;
         endcase
      end
   end

   // ---------------- checks ----------------
   logic [31:0] gap_cnt;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_cnt <= 32'h00000000;
      end else if (ce) begin
         gap_cnt <= t1_fire ? 32'h00000001 : gap_cnt + 32'h00000001;
      end
   end

   sequence launch_s;
      ce && launch_ok && !halt;
   endsequence

   sequence rx_wait_s;
      ce && st == S_RX && !halt;
   endsequence

   property stop_off_p;
      @(posedge hclk) disable iff (!hresetn)
      ce && stop_p |=> st == S_OFF && !seq_active;
   endproperty
   stop_forces_off_a: assert property (stop_off_p) // [RULE19]
      else $error("stop did not force off");

   fsk_gate_a: assert property ( // [RULE22]
      @(posedge hclk) disable iff (!hresetn)
      !trans[B_FSK_ON] |-> st == S_OFF || $past(trans[B_FSK_ON]))
      else $error("sequencer alive outside fsk mode");

   idle_mode_a: assert property ( // [RULE1]
      @(posedge hclk) disable iff (!hresetn)
      st == S_IDLE && $past(st) == S_IDLE && $stable(ctrl)
      |-> mode_req == (ctrl[B_IDLE_LP] ? M_SLEEP : M_STBY))
      else $error("idle mode wrong");

   start_rx_a: assert property ( // [RULE2]
      @(posedge hclk) disable iff (!hresetn)
      launch_s ##0 ctrl[B_START_LO +: 2] == 2'h1
      |=> st == S_RX ##0 mode_req == M_RX)
      else $error("start to rx failed");

   init_mode_a: assert property ( // [RULE4]
      @(posedge hclk) disable iff (!hresetn)
      launch_s |=> init_sleep == $past(chip_in_sleep))
      else $error("initial mode not recorded");

   idle_exit_a: assert property ( // [RULE5]
      @(posedge hclk) disable iff (!hresetn)
      ce && st == S_IDLE && t1_fire && !halt
      |=> st == ($past(ctrl[B_IDLE_EX]) ? S_RX : S_TX))
      else $error("idle exit wrong");

   idle_ignore_a: assert property ( // [RULE21]
      @(posedge hclk) disable iff (!hresetn)
      ce && st == S_IDLE && !t1_fire && !halt |=> st == S_IDLE)
      else $error("idle left without first timer");

   rx_t2_a: assert property ( // [RULE9]
      @(posedge hclk) disable iff (!hresetn)
      rx_wait_s ##0 t2_fire |=> st == S_LPSEL)
      else $error("second timer did not end rx");

   rx_tmo_a: assert property ( // [RULE12]
      @(posedge hclk) disable iff (!hresetn)
      rx_wait_s ##0 !t2_fire && rx_tmo
      ##0 trans[B_RX_EX_LO +: 3] == 3'h0 |=> st == S_TMO)
      else $error("rx timeout not taken");

   relaunch_a: assert property ( // [RULE11]
      @(posedge hclk) disable iff (!hresetn)
      ce && st == S_TMO && !halt && trans[B_TMO_EX_LO +: 2] == 2'h0
      |=> st == S_RX && rx_relaunch)
      else $error("timeout relaunch missing");

   t2_gap_a: assert property ( // [RULE15]
      @(posedge hclk) disable iff (!hresetn)
      ce && t2_fire |-> gap_cnt == 32'(res_count(timer[B_T2_SEL_LO +: 2]))
         * 32'(eff_mult(timer[B_T2_MUL_LO +: 8])))
      else $error("second timer interval wrong");

   irq_out_a: assert property ( // [RULE14]
      @(posedge hclk) disable iff (!hresetn)
      ce && t1_fire |=> first_timer_irq && !second_timer_irq)
      else $error("first timer output missing");

endmodule

// *** rtl/rmst_pkg.sv ***
// package: constants and types of the radio mode sequencer and its timers
package rmst_pkg;
   // clock rate and tick times in their own units
   localparam int  CLK_MHZ    = 25;
   localparam int  T_TICK1_US = 64;
   localparam real T_TICK2_MS = 4.1;
   localparam real T_TICK3_MS = 262.0;
   localparam int  TICK1_CYC  = T_TICK1_US * CLK_MHZ;
   localparam int  TICK2_DEF  = int'(T_TICK2_MS * 1000.0 * CLK_MHZ);
   localparam int  TICK3_DEF  = int'(T_TICK3_MS * 1000.0 * CLK_MHZ);
   // register byte offsets
   localparam logic [11:0] OFS_CTRL  = 12'h000;
   localparam logic [11:0] OFS_TRANS = 12'h004;
   localparam logic [11:0] OFS_TIMER = 12'h008;
   localparam logic [11:0] OFS_STAT  = 12'h00C;
   // control register fields
   localparam int B_LAUNCH   = 0;
   localparam int B_STOP     = 1;
   localparam int B_IDLE_LP  = 2;
   localparam int B_START_LO = 3;
   localparam int B_LP_CHO   = 5;
   localparam int B_IDLE_EX  = 6;
   localparam int B_TX_EX    = 7;
   // transition register fields
   localparam int B_RX_EX_LO  = 0;
   localparam int B_TMO_EX_LO = 3;
   localparam int B_PKT_EX_LO = 5;
   localparam int B_CRC_ON    = 8;
   localparam int B_CRC_FLUSH = 9;
   localparam int B_FSK_ON    = 10;
   // timer register fields
   localparam int B_T1_SEL_LO = 0;
   localparam int B_T2_SEL_LO = 2;
   localparam int B_T1_MUL_LO = 8;
   localparam int B_T2_MUL_LO = 16;
   // status register fields
   localparam int B_ST_LO   = 0;
   localparam int B_MODE_LO = 12;
   localparam int B_INIT    = 16;
   localparam int B_ACTIVE  = 17;
   // reset values
   localparam logic [7:0]  CTRL_RST  = 8'h00;
   localparam logic [10:0] TRANS_RST = 11'h400;
   localparam logic [23:0] TIMER_RST = 24'h000000;
   // chip mode codes
   localparam logic [2:0] M_SLEEP = 3'h0;
   localparam logic [2:0] M_STBY  = 3'h1;
   localparam logic [2:0] M_FS    = 3'h2;
   localparam logic [2:0] M_TX    = 3'h3;
   localparam logic [2:0] M_RX    = 3'h4;
   typedef enum logic [8:0] {
      S_OFF    = 9'h001,
      S_IDLE   = 9'h002,
      S_TX     = 9'h004,
      S_RX     = 9'h008,
      S_PKT    = 9'h010,
      S_LPSEL  = 9'h020,
      S_TMO    = 9'h040,
      S_FSHOP  = 9'h080,
      S_TXWAIT = 9'h100
   } rmst_state_e;
endpackage

// *** tb/rmst_host.sv ***
// host model: AHB-Lite single-word master driving the sequencer registers
`timescale 1ns/10ps
module rmst_host
   import rmst_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic      [31:0] haddr,
   output logic      [1:0]  htrans,
   output logic             hwrite,
   output logic      [31:0] hwdata,
   output logic             rd_valid,
   output logic      [31:0] rd_data
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      rd_valid = 1'b0;
      rd_data = 32'h0;
   end

   // address phase held until hready, then data phase held until hready
   task automatic xfer(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? d : 32'h0;
      do @(posedge hclk); while (hready !== 1'b1);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      // stop wins anyway, so launch is never sent alongside it
      if (a == OFS_CTRL && d[B_STOP]) d[B_LAUNCH] = 1'b0;
      xfer(a, 1'b1, d);
   endtask

   // read data taken at the data-phase edge, offered for one cycle
   task automatic rd(input logic [11:0] a);
      xfer(a, 1'b0, 32'h0);
      rd_data <= hrdata;
      rd_valid <= 1'b1;
      @(posedge hclk);
      rd_valid <= 1'b0;
   endtask
endmodule

// *** tb/rmst_core_tb.sv ***
// testbench: sequencer transitions, timers and registers of rmst_core
`timescale 1ns/10ps
module rmst_core_tb
   import rmst_pkg::*;
;
   localparam int T2C  = 20;
   localparam int T3C  = 40;
   localparam int CEIL = 6000;
   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        lp;
   logic        ce;
   logic        rlx;
   logic        sl;
   logic [10:0] ev;
   logic        seq_active;
   logic [2:0]  mode_req;
   logic        fti;
   logic        sti;
   logic        rd_valid;
   logic [31:0] rd_data;
   logic [31:0] rnd;
   logic [31:0] m1;
   logic [31:0] exp_rd[$];
   logic [31:0] exp_gap[$];
   int          miscompares;
   int          checks_done;
   int          relaunches;
   int          cyc;
   int          last;
   logic        gap_on;

   initial hclk = 1'b0;
   always #20 hclk = ~hclk;

   rmst_core #(.TICK2_CYC(T2C), .TICK3_CYC(T3C)) uut (
      .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .chip_in_lowpower(lp),
      .chip_in_sleep(sl), .tx_done_irq(ev[10]), .rx_payload_irq(ev[9]),
      .crc_good_irq(ev[8]), .rx_level_irq(ev[7]), .sync_match_irq(ev[6]),
      .preamble_seen_irq(ev[5]), .rx_level_timeout(ev[4]),
      .rx_preamble_timeout(ev[3]), .rx_sync_timeout(ev[2]),
      .fifo_level_irq(ev[1]), .fifo_drained_irq(ev[0]),
      .seq_active(seq_active), .mode_req(mode_req), .rx_relaunch(rlx),
      .first_timer_irq(fti), .second_timer_irq(sti));

   rmst_host host (
      .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
      .rd_valid(rd_valid), .rd_data(rd_data));

   function automatic logic [31:0] xs(logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [31:0] stw(logic [8:0] s, logic [2:0] m,
                                       logic i);
      return {14'h0, s != S_OFF, i, 1'b0, m, 3'h0, s};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: saw %h expected %h", $time, seen,
                  exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task automatic pulse(input logic [10:0] v);
      @(posedge hclk);
      ev <= v;
      @(posedge hclk);
      ev <= 11'h000;
      repeat (2) @(posedge hclk);
   endtask

   task automatic expect_st(input logic [8:0] s, input logic [2:0] m,
                            input logic i);
      repeat (2) @(posedge hclk);
      exp_rd.push_back(stw(s, m, i));
      host.rd(OFS_STAT);
   endtask

   // launch with a config, fire up to two events, check, then stop
   task automatic run(input logic [7:0] c, input logic [10:0] t,
                      input logic [10:0] e1, input logic [10:0] e2,
                      input logic [8:0] s, input logic [2:0] m);
      host.wr(OFS_TRANS, {21'h0, t});
      host.wr(OFS_CTRL, {24'h0, c | 8'h01});
      pulse(e1);
      pulse(e2);
      expect_st(s, m, sl);
      host.wr(OFS_CTRL, 32'h2);
   endtask

   // results are compared as they appear, against the oldest note
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (rlx === 1'b1)
         relaunches++;
      if (rd_valid === 1'b1 && exp_rd.size() > 0)
         chk(rd_data, exp_rd.pop_front());
      if (gap_on && (fti === 1'b1 || sti === 1'b1)) begin
         if (last != 0 && exp_gap.size() > 0)
            chk(32'(cyc - last), exp_gap.pop_front());
         last = cyc;
      end
      if (cyc == CEIL) begin
         miscompares++;
         report_and_stop();
      end
   end

   initial begin
      hresetn = 1'b0;
      lp = 1'b1;
      ce = 1'b1;
      relaunches = 0;
      sl = 1'b1;
      ev = 11'h000;
      rnd = 32'd43049;
      cyc = 0;
      last = 0;
      gap_on = 1'b0;
      miscompares = 0;
      checks_done = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      // reset values, unmapped offset reads zero
      exp_rd.push_back(32'h0);
      host.rd(OFS_CTRL);
      exp_rd.push_back(32'h400);
      host.rd(OFS_TRANS);
      exp_rd.push_back(32'h0);
      host.rd(12'h010);
      expect_st(S_OFF, M_STBY, 1'b0);
      $display("test reset done");
      // idle in sleep; random events must not move it; stop forces off
      host.wr(OFS_TRANS, 32'h4E0);
      host.wr(OFS_CTRL, 32'h25);
      expect_st(S_IDLE, M_SLEEP, 1'b1);
      repeat (16) begin
         rnd = xs(rnd);
         @(posedge hclk);
         ev <= rnd[10:0];
      end
      @(posedge hclk);
      ev <= 11'h000;
      expect_st(S_IDLE, M_SLEEP, 1'b1);
      host.wr(OFS_CTRL, 32'h2);
      expect_st(S_OFF, M_SLEEP, 1'b1);
      $display("test idle done");
      sl <= 1'b0;
      run(8'h00, 11'h4E0, 11'h000, 11'h000, S_OFF, M_STBY);
      run(8'h20, 11'h4E0, 11'h000, 11'h000, S_IDLE, M_STBY);
      run(8'h08, 11'h4E1, 11'h200, 11'h000, S_PKT, M_RX);
      run(8'h08, 11'h4E2, 11'h200, 11'h000, S_OFF, M_STBY);
      run(8'h08, 11'h4E3, 11'h100, 11'h000, S_PKT, M_RX);
      run(8'h08, 11'h4E0, 11'h200, 11'h000, S_RX, M_RX);
      run(8'h08, 11'h4E4, 11'h080, 11'h000, S_OFF, M_STBY);
      run(8'h08, 11'h4E5, 11'h040, 11'h000, S_OFF, M_STBY);
      run(8'h08, 11'h4E6, 11'h020, 11'h000, S_OFF, M_STBY);
      run(8'h08, 11'h5EB, 11'h200, 11'h000, S_TX, M_TX);
      run(8'h08, 11'h4E0, 11'h010, 11'h000, S_RX, M_RX);
      run(8'h08, 11'h4E8, 11'h008, 11'h000, S_TX, M_TX);
      run(8'h08, 11'h4F0, 11'h004, 11'h000, S_OFF, M_STBY);
      run(8'h08, 11'h4F8, 11'h010, 11'h000, S_OFF, M_STBY);
      run(8'h08, 11'h401, 11'h200, 11'h000, S_OFF, M_STBY);
      run(8'h08, 11'h421, 11'h200, 11'h001, S_TX, M_TX);
      run(8'h08, 11'h441, 11'h200, 11'h000, S_OFF, M_STBY);
      run(8'h08, 11'h461, 11'h200, 11'h000, S_RX, M_RX);
      run(8'h08, 11'h481, 11'h200, 11'h200, S_RX, M_RX);
      run(8'h90, 11'h4E0, 11'h400, 11'h000, S_RX, M_RX);
      run(8'h10, 11'h4E0, 11'h400, 11'h000, S_OFF, M_STBY);
      run(8'h18, 11'h4E0, 11'h000, 11'h000, S_TXWAIT, M_STBY);
      run(8'h18, 11'h4E0, 11'h002, 11'h000, S_TX, M_TX);
      // launch outside sleep or standby is lost
      lp <= 1'b0;
      run(8'h08, 11'h4E0, 11'h000, 11'h000, S_OFF, M_STBY);
      lp <= 1'b1;
      // frozen clock enable: pending launch kept, payload meanwhile unseen
      host.wr(OFS_TRANS, 32'h4E1);
      host.wr(OFS_CTRL, 32'h09);
      ce <= 1'b0;
      pulse(11'h200);
      ce <= 1'b1;
      expect_st(S_RX, M_RX, sl);
      host.wr(OFS_CTRL, 32'h2);
      run(8'h08, 11'h0E0, 11'h000, 11'h000, S_OFF, M_STBY);
      $display("test transitions done");
      // timers: second multiplier zero acts as one tick
      rnd = xs(rnd);
      m1 = {30'h0, rnd[1:0]} + 32'h1;
      host.wr(OFS_TIMER, (m1 << 8) | 32'hE);
      host.wr(OFS_TRANS, 32'h4E0);
      exp_gap.push_back(T3C);
      exp_gap.push_back(T2C * m1);
      exp_gap.push_back(T3C);
      gap_on = 1'b1;
      host.wr(OFS_CTRL, 32'h69);
      do @(posedge hclk); while (sti !== 1'b1);
      expect_st(S_IDLE, M_STBY, 1'b0);
      do @(posedge hclk); while (fti !== 1'b1);
      expect_st(S_RX, M_RX, 1'b0);
      do @(posedge hclk); while (sti !== 1'b1);
      expect_st(S_IDLE, M_STBY, 1'b0);
      host.wr(OFS_CTRL, 32'h2);
      gap_on = 1'b0;
      repeat (3) @(posedge hclk);
      chk(32'(exp_gap.size()), 32'h0);
      chk(32'(exp_rd.size()), 32'h0);
      chk(32'(relaunches), 32'h1);
      $display("test timers done");
      report_and_stop();
   end
endmodule
